// ### pmic_far.sv
// far side model: interrupt sources and core units
`timescale 1ns/10ps
module pmic_far
	import pmic_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 core_halt_i,
	output logic      [31:0]          irq_lines_o,
	output logic      [NUM_UNITS-1:0] unit_idle_o,
	output logic      [NUM_UNITS-1:0] unit_enabled_o
);
	logic [NUM_UNITS-1:0] busy_q;

	initial begin
		irq_lines_o = 32'h0;
		busy_q = 6'h3f;
		unit_enabled_o = 6'h3f;
	end

	// a halted core has nothing in flight, so every unit is idle
	assign unit_idle_o = core_halt_i ? 6'h3f : ~busy_q;

	// =========================================================
	// level requests stay until the source itself drops them
	task automatic set_line(input int n, input logic v);
		@(posedge mclk_i);
		irq_lines_o[n] <= v;
	endtask

	task automatic set_units(input logic [5:0] idle, input logic [5:0] en);
		@(posedge mclk_i);
		busy_q <= ~idle;
		unit_enabled_o <= en;
	endtask
endmodule

// ### pmic_gate.sv
// per-unit clock enables from mode and idle status
`timescale 1ns/10ps
module pmic_gate
	import pmic_pkg::*;
(
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire pmic_mode_t           mode_i,
	input  wire logic                 dyn_en_i,
	input  wire logic [NUM_UNITS-1:0] unit_idle_i,
	input  wire logic [NUM_UNITS-1:0] unit_enabled_i,
	output logic      [NUM_UNITS-1:0] unit_clk_en_o,
	output logic                      timer_clk_en_o,
	output logic                      irqc_clk_en_o
);
	logic [NUM_UNITS-1:0] frozen_q, frozen_d;
	logic                 dyn_q;

	// disabled units seen as dyn gating turns on stay off until re-enabled
	always_comb begin
		frozen_d = frozen_q;
		if (!dyn_en_i) begin
			frozen_d = '0;
		end else if (!dyn_q) begin
			frozen_d = DISABLEABLE & ~unit_enabled_i;
		end else begin
			frozen_d = frozen_q & ~unit_enabled_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			frozen_q <= '0;
			dyn_q    <= 1'b0;
		end else begin
			frozen_q <= frozen_d;
			dyn_q    <= dyn_en_i;
		end
	end

	always_comb begin
		unit_clk_en_o = '1;
		if (mode_i != MODE_RUN) begin
			unit_clk_en_o = '0;
		end else if (dyn_en_i) begin
			unit_clk_en_o = ~unit_idle_i & ~frozen_d;
		end
		// timer and controller keep running only in run and doze
		timer_clk_en_o = mode_i inside {MODE_RUN, MODE_DOZE};
		irqc_clk_en_o  = mode_i inside {MODE_RUN, MODE_DOZE};
	end

	chk_lowpower_off: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_i == MODE_SLEEP |-> unit_clk_en_o == '0 && !timer_clk_en_o)
		else $error("clock running in sleep");
	chk_turnon_off: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		dyn_en_i && !dyn_q
		|-> (unit_clk_en_o & DISABLEABLE & ~unit_enabled_i) == '0)
		else $error("disabled unit clocked at gating turn-on");
	chk_frozen_off: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		dyn_en_i && dyn_q
		|-> (unit_clk_en_o & frozen_q & ~unit_enabled_i) == '0)
		else $error("disabled cache clock not held off");
endmodule

// ### pmic_irq.sv
// interrupt controller: unmask and pending status registers
`timescale 1ns/10ps
module pmic_irq
	import pmic_pkg::*;
#(
	parameter int          NUM_IRQ     = 32,
	parameter logic [31:0] EDGE_SRC    = 32'h0000_0000,
	parameter logic [1:0]  FIXED_UNMASK = 2'h0,
	parameter bit          IMPLEMENTED = 1'b1
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [31:0] irq_sync_i,
	input  wire logic        unmask_we_i,
	input  wire logic        pending_we_i,
	input  wire logic [31:0] wdata_i,
	output logic      [31:0] unmask_o,
	output logic      [31:0] pending_o,
	output logic             irq_o
);
	logic [31:0] unmask_q, unmask_d;
	logic [31:0] latch_q, latch_d;
	logic [31:0] prev_q;
	logic [31:0] pending;

	// ===========================================================
	// per-input status
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_src
			if (g >= NUM_IRQ) begin : g_none
				assign pending[g] = 1'b0;
				assign latch_d[g] = 1'b0;
			end else if (EDGE_SRC[g]) begin : g_edge
				// new edge wins over a same-cycle clear
				assign latch_d[g] = (irq_sync_i[g] & ~prev_q[g]) |
					(latch_q[g] & ~(pending_we_i & wdata_i[g]));
				assign pending[g] = latch_q[g];
			end else begin : g_level
				assign latch_d[g] = 1'b0;
				assign pending[g] = irq_sync_i[g];
			end
		end
	endgenerate

	always_comb begin
		unmask_d = unmask_q;
		if (unmask_we_i) begin
			unmask_d = wdata_i;
		end
		unmask_d[1:0] = unmask_d[1:0] | FIXED_UNMASK;
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unmask_q <= UNMASK_RESET;
			latch_q  <= PENDING_RESET;
			prev_q   <= 32'h0000_0000;
		end else begin
			unmask_q <= unmask_d;
			latch_q  <= latch_d;
			prev_q   <= irq_sync_i;
		end
	end

	assign unmask_o  = unmask_q | {30'h0, FIXED_UNMASK};
	assign pending_o = pending;
	// bypass when no controller: raw line straight to exception input
	assign irq_o = IMPLEMENTED ? |(pending & unmask_o)
		: irq_sync_i[0];

	// every edge input at once, so any configured edge bit is exercised
	chk_edge_clear: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		pending_we_i |=> (pending_o & EDGE_SRC
		& $past(wdata_i & ~irq_sync_i)) == 32'h0000_0000)
		else $error("edge latch not cleared by write of one");
	chk_edge_keep: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		pending_we_i |=> ($past(pending_o & ~wdata_i) & EDGE_SRC
		& ~pending_o) == 32'h0000_0000)
		else $error("edge latch lost on write of zero");
	chk_unmask_write: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		unmask_we_i |=> unmask_o[31:2] == $past(wdata_i[31:2]))
		else $error("unmask register did not take write");
	chk_irq_gate: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		IMPLEMENTED |-> irq_o == |(pending_o & unmask_o))
		else $error("interrupt request not gated by unmask");
endmodule

// ### pmic_pkg.sv
// shared constants and types for the power mode and interrupt controller
package pmic_pkg;

	// ===========================================================
	// special-register selection
	localparam logic [1:0] SEL_POWER_CONTROL = 2'h0;
	localparam logic [1:0] SEL_UNMASK        = 2'h1;
	localparam logic [1:0] SEL_PENDING       = 2'h2;

	// ===========================================================
	// power_control field layout
	localparam int SDF_LSB     = 0;
	localparam int SDF_W       = 4;
	localparam int DOZE_BIT    = 4;
	localparam int SLEEP_BIT   = 5;
	localparam int DYNGATE_BIT = 6;
	localparam int SUSP_BIT    = 7;
	localparam logic [31:0] POWER_RESET   = 32'h0000_0000;
	localparam logic [31:0] UNMASK_RESET  = 32'h0000_0000;
	localparam logic [31:0] PENDING_RESET = 32'h0000_0000;
	localparam logic [3:0]  SDF_FULL      = 4'h0;

	// ===========================================================
	// gated units
	localparam int UNIT_PIPE = 0;
	localparam int UNIT_FPU  = 1;
	localparam int UNIT_IC   = 2;
	localparam int UNIT_DC   = 3;
	localparam int UNIT_IMMU = 4;
	localparam int UNIT_DMMU = 5;
	localparam int NUM_UNITS = 6;
	// caches and MMUs: units that can be disabled by software
	localparam logic [5:0] DISABLEABLE = 6'h3c;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_DOZE,
		MODE_SLEEP,
		MODE_SUSPEND
	} pmic_mode_t;

	// special-register move request from the core
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [1:0]  sel;
		logic        supervisor;
		logic [31:0] wdata;
	} pmic_spr_req_t;

endpackage

// ### pmic_top.sv
// power mode and interrupt controller top level
`timescale 1ns/10ps
module pmic_top
	import pmic_pkg::*;
#(
	parameter int          NUM_IRQ      = 32,
	parameter logic [31:0] EDGE_SRC     = 32'h0000_0000,
	parameter logic [1:0]  FIXED_UNMASK = 2'h0,
	parameter bit          IRQC_PRESENT = 1'b1
) (
	input  wire logic                 mclk_i,
	input  wire logic                 rst_n_i,
	input  wire pmic_spr_req_t        spr_req_i,
	output logic      [31:0]          spr_rdata_o,
	output logic                      spr_err_o,
	input  wire logic [31:0]          irq_lines_i,
	input  wire logic [NUM_UNITS-1:0] unit_idle_i,
	input  wire logic [NUM_UNITS-1:0] unit_enabled_i,
	output logic      [3:0]           slow_down_factor_o,
	output logic                      core_halt_o,
	output logic                      low_voltage_req_o,
	output logic      [NUM_UNITS-1:0] unit_clk_en_o,
	output logic                      timer_clk_en_o,
	output logic                      irqc_clk_en_o,
	output logic                      core_irq_o
);
	// ===========================================================
	// input synchronisers
	logic [31:0] irq_meta_q, irq_sync_q;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_meta_q <= 32'h0000_0000;
			irq_sync_q <= 32'h0000_0000;
		end else begin
			irq_meta_q <= irq_lines_i;
			irq_sync_q <= irq_meta_q;
		end
	end

	// ===========================================================
	// register access decode
	logic access_ok;
	logic wr_power, wr_unmask, wr_pending;

	// non-supervisor moves are refused and flagged
	assign access_ok  = spr_req_i.supervisor;
	assign wr_power   = spr_req_i.wr && access_ok &&
		spr_req_i.sel == SEL_POWER_CONTROL;
	assign wr_unmask  = spr_req_i.wr && access_ok &&
		spr_req_i.sel == SEL_UNMASK;
	assign wr_pending = spr_req_i.wr && access_ok &&
		spr_req_i.sel == SEL_PENDING;

	// ===========================================================
	// interrupt controller
	logic [31:0] unmask, pending;
	logic        irq_req;

	pmic_irq #(
		.NUM_IRQ      (NUM_IRQ),
		.EDGE_SRC     (EDGE_SRC),
		.FIXED_UNMASK (FIXED_UNMASK),
		.IMPLEMENTED  (IRQC_PRESENT)
	) u_irq (
		.mclk_i       (mclk_i),
		.rst_n_i      (rst_n_i),
		.irq_sync_i   (irq_sync_q),
		.unmask_we_i  (wr_unmask),
		.pending_we_i (wr_pending),
		.wdata_i      (spr_req_i.wdata),
		.unmask_o     (unmask),
		.pending_o    (pending),
		.irq_o        (irq_req)
	);

	assign core_irq_o = irq_req;

	// ===========================================================
	// power control register and mode sequencer
	logic [3:0] sdf_q, sdf_d;
	logic       doze_q, doze_d;
	logic       sleep_q, sleep_d;
	logic       dyn_q, dyn_d;
	logic       susp_q, susp_d;
	pmic_mode_t mode_q, mode_d;

	always_comb begin
		sdf_d   = sdf_q;
		doze_d  = doze_q;
		sleep_d = sleep_q;
		dyn_d   = dyn_q;
		susp_d  = susp_q;
		if (wr_power) begin
			sdf_d   = spr_req_i.wdata[SDF_LSB +: SDF_W];
			doze_d  = spr_req_i.wdata[DOZE_BIT];
			sleep_d = spr_req_i.wdata[SLEEP_BIT];
			dyn_d   = spr_req_i.wdata[DYNGATE_BIT];
			susp_d  = spr_req_i.wdata[SUSP_BIT];
		end
		// wake beats a same-cycle write; suspend ignores interrupts
		if (irq_req && mode_q inside {MODE_DOZE, MODE_SLEEP}) begin
			doze_d  = 1'b0;
			sleep_d = 1'b0;
		end
		mode_d = mode_q;
		unique case (mode_q)
			MODE_RUN: begin
				if (susp_q) begin
					mode_d = MODE_SUSPEND;
				end else if (sleep_q) begin
					mode_d = MODE_SLEEP;
				end else if (doze_q) begin
					mode_d = MODE_DOZE;
				end
			end
			MODE_DOZE: begin
				if (irq_req) begin
					mode_d = MODE_RUN;
				end
			end
			MODE_SLEEP: begin
				if (irq_req) begin
					mode_d = MODE_RUN;
				end
			end
			MODE_SUSPEND: begin
				mode_d = MODE_SUSPEND;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sdf_q   <= POWER_RESET[SDF_LSB +: SDF_W];
			doze_q  <= POWER_RESET[DOZE_BIT];
			sleep_q <= POWER_RESET[SLEEP_BIT];
			dyn_q   <= POWER_RESET[DYNGATE_BIT];
			susp_q  <= POWER_RESET[SUSP_BIT];
			mode_q  <= MODE_RUN;
		end else begin
			sdf_q   <= sdf_d;
			doze_q  <= doze_d;
			sleep_q <= sleep_d;
			dyn_q   <= dyn_d;
			susp_q  <= susp_d;
			mode_q  <= mode_d;
		end
	end

	// factor passes to the clock generator, which owns the divider
	assign slow_down_factor_o = sdf_q;
	assign core_halt_o        = mode_q != MODE_RUN;
	// optional supply drop, requested only in the deep modes
	assign low_voltage_req_o  = mode_q inside {MODE_SLEEP, MODE_SUSPEND};

	// ===========================================================
	// clock gating
	pmic_gate u_gate (
		.mclk_i         (mclk_i),
		.rst_n_i        (rst_n_i),
		.mode_i         (mode_q),
		.dyn_en_i       (dyn_q),
		.unit_idle_i    (unit_idle_i),
		.unit_enabled_i (unit_enabled_i),
		.unit_clk_en_o  (unit_clk_en_o),
		.timer_clk_en_o (timer_clk_en_o),
		.irqc_clk_en_o  (irqc_clk_en_o)
	);

	// ===========================================================
	// read data, registered one cycle after the move
	logic [31:0] rdata_q, rdata_d;
	logic        err_q, err_d;

	always_comb begin
		rdata_d = 32'h0000_0000;
		err_d   = (spr_req_i.wr || spr_req_i.rd) && !access_ok;
		if (spr_req_i.rd && access_ok) begin
			unique case (spr_req_i.sel)
				SEL_POWER_CONTROL: rdata_d = {24'h0, susp_q, dyn_q,
					sleep_q, doze_q, sdf_q};
				SEL_UNMASK:  rdata_d = unmask;
				SEL_PENDING: rdata_d = pending;
				default: begin
					err_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0000_0000;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	assign spr_rdata_o = rdata_q;
	assign spr_err_o   = err_q;

	// ===========================================================
	// checks
	chk_doze_wake: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_DOZE && irq_req |=> mode_q == MODE_RUN && !doze_q)
		else $error("doze not left on interrupt");
	chk_sleep_wake: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SLEEP && irq_req |=> mode_q == MODE_RUN)
		else $error("sleep not left on interrupt");
	chk_sleep_clear: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SLEEP && irq_req |=> !sleep_q)
		else $error("sleep bit kept after wake");
	chk_sleep_hold: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SLEEP && !irq_req |=> mode_q == MODE_SLEEP)
		else $error("sleep left without interrupt");
	chk_sleep_entry: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_RUN && sleep_q && !susp_q |=> mode_q == MODE_SLEEP)
		else $error("sleep not entered");
	chk_suspend_entry: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_RUN && susp_q |=> mode_q == MODE_SUSPEND)
		else $error("suspend not entered");
	chk_suspend_hold: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SUSPEND |=> mode_q == MODE_SUSPEND [*3])
		else $error("suspend left without reset");
	chk_suspend_clocks: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SUSPEND |-> unit_clk_en_o == '0 && !timer_clk_en_o
		&& !irqc_clk_en_o)
		else $error("clock running in suspend");
	chk_doze_entry: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_RUN && doze_q && !sleep_q && !susp_q
		|=> mode_q == MODE_DOZE)
		else $error("doze not entered");
	chk_doze_clocks: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_DOZE |-> irqc_clk_en_o && timer_clk_en_o
		&& unit_clk_en_o == '0)
		else $error("doze clock gating wrong");
	chk_static_clocks: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_RUN && !dyn_q |-> unit_clk_en_o == '1 && timer_clk_en_o)
		else $error("unit clock gated with dynamic gating off");
	chk_sdf_write: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_power |=> slow_down_factor_o == $past(spr_req_i.wdata[3:0]))
		else $error("slow-down factor not written");
	chk_user_refused: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		spr_req_i.wr && !spr_req_i.supervisor
		|=> $stable(sdf_q) && spr_err_o)
		else $error("user write not refused");
	chk_user_read: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		spr_req_i.rd && !spr_req_i.supervisor
		|=> spr_rdata_o == 32'h0000_0000 && spr_err_o)
		else $error("user read not refused");
	chk_rdata_idle: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		!spr_req_i.rd |=> spr_rdata_o == 32'h0000_0000)
		else $error("read data shown without a read");
	chk_unmapped_err: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		spr_req_i.rd && spr_req_i.supervisor && spr_req_i.sel == 2'h3
		|=> spr_err_o)
		else $error("unmapped read not flagged");
	chk_reserved_zero: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		spr_req_i.rd && spr_req_i.sel == SEL_POWER_CONTROL
		|=> spr_rdata_o[31:8] == 24'h00_0000)
		else $error("reserved control bits read nonzero");
	// watches input 3, the level source that the scenarios drive
	chk_irq_pipe: assert property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		NUM_IRQ > 3 && !EDGE_SRC[3] && $rose(irq_lines_i[3]) |-> ##2 pending[3])
		else $error("level input not reflected two cycles later");

	cov_doze_wake: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_DOZE ##1 mode_q == MODE_RUN);
	cov_sleep_wake: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SLEEP ##1 mode_q == MODE_RUN);
	cov_suspend: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		mode_q == MODE_SUSPEND);
	cov_dyn_gate: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		dyn_q && mode_q == MODE_RUN && unit_clk_en_o != '1);
endmodule

// ### pmic_top_test.sv
// self-checking bench for the power mode and interrupt controller
`timescale 1ns/10ps
module pmic_top_test;
	import pmic_pkg::*;
	logic                 mclk_i;
	logic                 rst_n_i;
	pmic_spr_req_t        spr_req_i;
	logic [31:0]          spr_rdata_o;
	logic                 spr_err_o;
	logic [31:0]          irq_lines_i;
	logic [NUM_UNITS-1:0] unit_idle_i;
	logic [NUM_UNITS-1:0] unit_enabled_i;
	logic [3:0]           slow_down_factor_o;
	logic                 core_halt_o;
	logic                 low_voltage_req_o;
	logic [NUM_UNITS-1:0] unit_clk_en_o;
	logic                 timer_clk_en_o;
	logic                 irqc_clk_en_o;
	logic                 core_irq_o;
	logic [31:0]          r;
	logic                 e;
	logic [31:0]          rdata2;
	logic                 core_irq2;
	logic [31:0]          r2;
	int                   bad_count;
	int                   n_checks;

	pmic_top #(
		.EDGE_SRC(32'h0000_0010)
	) dut (
		.mclk_i            (mclk_i),
		.rst_n_i           (rst_n_i),
		.spr_req_i         (spr_req_i),
		.spr_rdata_o       (spr_rdata_o),
		.spr_err_o         (spr_err_o),
		.irq_lines_i       (irq_lines_i),
		.unit_idle_i       (unit_idle_i),
		.unit_enabled_i    (unit_enabled_i),
		.slow_down_factor_o(slow_down_factor_o),
		.core_halt_o       (core_halt_o),
		.low_voltage_req_o (low_voltage_req_o),
		.unit_clk_en_o     (unit_clk_en_o),
		.timer_clk_en_o    (timer_clk_en_o),
		.irqc_clk_en_o     (irqc_clk_en_o),
		.core_irq_o        (core_irq_o)
	);

	pmic_far far (
		.mclk_i        (mclk_i),
		.core_halt_i   (core_halt_o),
		.irq_lines_o   (irq_lines_i),
		.unit_idle_o   (unit_idle_i),
		.unit_enabled_o(unit_enabled_i)
	);

	// second copy: fixed unmask pair and no controller behind the line
	pmic_top #(
		.FIXED_UNMASK(2'h3),
		.IRQC_PRESENT(1'b0)
	) dut2 (
		.mclk_i            (mclk_i),
		.rst_n_i           (rst_n_i),
		.spr_req_i         (spr_req_i),
		.spr_rdata_o       (rdata2),
		.spr_err_o         (),
		.irq_lines_i       (irq_lines_i),
		.unit_idle_i       (unit_idle_i),
		.unit_enabled_i    (unit_enabled_i),
		.slow_down_factor_o(),
		.core_halt_o       (),
		.low_voltage_req_o (),
		.unit_clk_en_o     (),
		.timer_clk_en_o    (),
		.irqc_clk_en_o     (),
		.core_irq_o        (core_irq2)
	);

	initial mclk_i = 1'b0;
	always #25 mclk_i = ~mclk_i;

	// =========================================================
	// access and comparison tasks
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one move, answer taken one cycle after the request edge
	task automatic spr(input logic wr, input logic [1:0] sel,
		input logic sup, input logic [31:0] wd);
		@(posedge mclk_i);
		spr_req_i <= '{wr: wr, rd: ~wr, sel: sel, supervisor: sup, wdata: wd};
		@(posedge mclk_i);
		spr_req_i <= '0;
		#1;
		r = spr_rdata_o;
		e = spr_err_o;
		r2 = rdata2;
	endtask

	task automatic wr_reg(input logic [1:0] sel, input logic [31:0] wd,
		input logic sup = 1'b1);
		spr(1'b1, sel, sup, wd);
		check("write error flag", {31'h0, ~sup}, {31'h0, e});
	endtask

	task automatic rd_reg(input logic [1:0] sel, input logic [31:0] exp,
		input string what);
		spr(1'b0, sel, 1'b1, 32'h0);
		check(what, exp, r);
	endtask

	// longest input-to-request path is three edges
	task automatic settle;
		repeat (4) @(posedge mclk_i);
		#1;
	endtask

	task automatic wait_halt(input logic exp);
		int i;
		for (i = 0; i < 10 && core_halt_o !== exp; i++) begin
			@(posedge mclk_i);
			#1;
		end
		check("core halt", {31'h0, exp}, {31'h0, core_halt_o});
		// a mode that never arrives would hang the rest of the run
		if (core_halt_o !== exp) begin
			end_sim;
		end
	endtask

	task automatic do_reset;
		rst_n_i <= 1'b0;
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// unit enables, timer enable, controller enable in one word
	function automatic logic [31:0] clks();
		return {24'h0, unit_clk_en_o, timer_clk_en_o, irqc_clk_en_o};
	endfunction

	initial begin
		repeat (20000) @(posedge mclk_i);
		bad_count++;
		end_sim;
	end

	// =========================================================
	// main sequence
	initial begin
		spr_req_i = '0;
		bad_count = 0;
		n_checks = 0;
		do_reset;
		rd_reg(SEL_POWER_CONTROL, POWER_RESET, "power_control");
		rd_reg(SEL_UNMASK, UNMASK_RESET, "unmask reset");
		check("fixed unmask", 32'h0000_0003, r2);
		rd_reg(SEL_PENDING, PENDING_RESET, "pending reset");
		check("run clocks", 32'hff, clks());
		wr_reg(SEL_POWER_CONTROL, 32'hffff_ff0f);
		check("slow down", 32'hf, {28'h0, slow_down_factor_o});
		rd_reg(SEL_POWER_CONTROL, 32'h0000_000f, "power_control");
		wr_reg(SEL_POWER_CONTROL, 32'h0);
		check("full speed", {28'h0, SDF_FULL}, {28'h0, slow_down_factor_o});
		// user mode moves are refused
		wr_reg(SEL_UNMASK, 32'hffff_ffff, 1'b0);
		rd_reg(SEL_UNMASK, 32'h0, "unmask after user write");
		spr(1'b0, 2'h3, 1'b1, 32'h0);
		check("unmapped read error", 32'h1, {31'h0, e});
		// level source, masked then unmasked
		far.set_line(3, 1'b1);
		settle;
		check("masked request", 32'h0, {31'h0, core_irq_o});
		rd_reg(SEL_PENDING, 32'h8, "level pending");
		wr_reg(SEL_PENDING, 32'hffff_ffef);
		rd_reg(SEL_PENDING, 32'h8, "pending after write");
		wr_reg(SEL_UNMASK, 32'hffff_ffff);
		rd_reg(SEL_UNMASK, 32'hffff_ffff, "unmask");
		check("unmasked request", 32'h1, {31'h0, core_irq_o});
		far.set_line(3, 1'b0);
		settle;
		check("request dropped", 32'h0, {31'h0, core_irq_o});
		rd_reg(SEL_PENDING, 32'h0, "level cleared");
		// edge source on input 4 keeps its latch
		far.set_line(4, 1'b1);
		far.set_line(4, 1'b0);
		settle;
		wr_reg(SEL_PENDING, 32'h0);
		rd_reg(SEL_PENDING, 32'h10, "edge latch kept");
		check("edge request", 32'h1, {31'h0, core_irq_o});
		wr_reg(SEL_PENDING, 32'h10);
		rd_reg(SEL_PENDING, 32'h0, "edge latch cleared");
		check("edge request gone", 32'h0, {31'h0, core_irq_o});
		// without a controller input 0 goes straight to the request
		far.set_line(0, 1'b1);
		settle;
		check("bypass request", 32'h1, {31'h0, core_irq2});
		far.set_line(0, 1'b0);
		settle;
		check("bypass dropped", 32'h0, {31'h0, core_irq2});
		// doze: timer and controller keep running
		wr_reg(SEL_POWER_CONTROL, 32'h10);
		wait_halt(1'b1);
		check("doze clocks", 32'h03, clks());
		far.set_line(3, 1'b1);
		wait_halt(1'b0);
		rd_reg(SEL_POWER_CONTROL, 32'h0, "doze bit after wake");
		far.set_line(3, 1'b0);
		settle;
		// sleep: everything gated, low voltage asked
		wr_reg(SEL_POWER_CONTROL, 32'h20);
		wait_halt(1'b1);
		check("sleep clocks", 32'h00, clks());
		check("low voltage", 32'h1, {31'h0, low_voltage_req_o});
		far.set_line(3, 1'b1);
		wait_halt(1'b0);
		far.set_line(3, 1'b0);
		settle;
		// suspend: an interrupt does not wake, only reset
		wr_reg(SEL_POWER_CONTROL, 32'h80);
		wait_halt(1'b1);
		far.set_line(3, 1'b1);
		settle;
		check("suspend halt", 32'h1, {31'h0, core_halt_o});
		check("suspend clocks", 32'h00, clks());
		far.set_line(3, 1'b0);
		do_reset;
		wait_halt(1'b0);
		// dynamic gating with the data cache disabled at turn-on
		far.set_units(6'h05, 6'h37);
		wr_reg(SEL_POWER_CONTROL, 32'h40);
		settle;
		check("gated units", 32'h32, {26'h0, unit_clk_en_o});
		far.set_units(6'h05, 6'h3f);
		settle;
		check("cache enabled again", 32'h3a, {26'h0, unit_clk_en_o});
		wr_reg(SEL_POWER_CONTROL, 32'h0);
		settle;
		check("gating off", 32'h3f, {26'h0, unit_clk_en_o});
		end_sim;
	end
endmodule
